// ---- shared/pfc_defines.svh ----
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

// ---------------------------------------------
// Sizes
// ---------------------------------------------
`define PFC_NFIX 3
`define PFC_CW 40
`define PFC_AW 4
`define PFC_DW 64

// ---------------------------------------------
// Register indices
// ---------------------------------------------
`define PFC_A_FX0 4'h0
`define PFC_A_FX1 4'h1
`define PFC_A_FX2 4'h2
`define PFC_A_GC0 4'h3
`define PFC_A_EVSEL0 4'h4
`define PFC_A_FXCTL 4'h5
`define PFC_A_GEN 4'h6
`define PFC_A_GSTAT 4'h7
`define PFC_A_GCLR 4'h8
`define PFC_A_SAMPEN 4'h9
`define PFC_A_CAP 4'hA
`define PFC_A_DBG 4'hB

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define PFC_FC_OS 0
`define PFC_FC_USR 1
`define PFC_FC_INT 3
`define PFC_FC_W 4
`define PFC_ES_USR 16
`define PFC_ES_OS 17
`define PFC_ES_INT 20
`define PFC_ES_EN 22
`define PFC_GS_FIX 32
`define PFC_DBG_LBR 0
`define PFC_DBG_TR 6
`define PFC_DBG_BTS 7
`define PFC_DBG_BTM 8
`define PFC_DBG_FRZ 14
`define PFC_DBG_MASK 16'h41C1
`define PFC_DBG_OFF 16'h01C1

// ---------------------------------------------
// Capability values
// ---------------------------------------------
`define PFC_CAP_TRAP 1'h1
`define PFC_CAP_ARCH 1'h1
`define PFC_CAP_FMT 4'h0
`define PFC_CAP_FRZ 1'h1
`define PFC_INFO_N 5'h03
`define PFC_INFO_W 8'h28

// ---------------------------------------------
// Sampling-eligible event codes
// ---------------------------------------------
`define PFC_EV_C0 16'hC000
`define PFC_EV_C1 16'hC1FE
`define PFC_EV_C5 16'hC500
`define PFC_EV_C7 16'hC71F
`define PFC_EV_CB1 16'hCB01
`define PFC_EV_CB2 16'hCB02
`define PFC_EV_CB4 16'hCB04
`define PFC_EV_CB8 16'hCB08
`define PFC_EV_CB10 16'hCB10

`endif

// ---- shared/pfc_pkg.sv ----
`include "pfc_defines.svh"

package pfc_pkg;

   // Sample and branch-store sequencer
   typedef enum logic [1:0] {
      PFC_IDLE = 2'b00,
      PFC_SAMPLE = 2'b01,
      PFC_BSTORE = 2'b10
   } pfc_state_e;

   // Register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`PFC_AW-1:0] addr;
      logic [`PFC_DW-1:0] wdata;
   } pfc_msr_s;

   // Event inputs from the core
   typedef struct packed {
      logic [`PFC_NFIX-1:0] fixed;
      logic gen;
      logic ring0;
      logic bts_req;
      logic [63:0] ip;
   } pfc_evt_s;

   // Whole block state
   typedef struct packed {
      logic [`PFC_NFIX-1:0][`PFC_CW-1:0] fx_cnt;
      logic [`PFC_CW-1:0] gc0;
      logic [31:0] evsel;
      logic [`PFC_NFIX*`PFC_FC_W-1:0] fctl;
      logic [`PFC_NFIX:0] ge;
      logic [`PFC_NFIX:0] ovf;
      logic sampen;
      logic [15:0] dbg;
      logic [`PFC_NFIX:0] sv_ge;
      logic [15:0] sv_dbg;
      logic in_smm;
      logic irq_pend;
      logic samp_pend;
      logic bts_pend;
      pfc_state_e st;
      logic [63:0] rec_ip;
      logic [`PFC_DW-1:0] rdata;
      logic rvalid;
      logic irq;
   } pfc_regs_s;

endpackage

// ---- rtl/pfc_ctrl.sv ----
`timescale 1ns/10ps
// What this block does
// (R1) One 4-bit control field per fixed counter
// (R2) Enable bit 0 counts ring-zero events
// (R3) Enable bit 1 counts events above ring zero
// (R4) 00 halts counter, 11 counts everywhere
// (R5) Field bit 3 requests interrupt on overflow
// (R6) Global enable ANDed with local enables
// (R7) One status read shows all overflows
// (R8) One write clears chosen overflow bits
// (R9) Report fixed counter count and width
// (R10) Software writes zero above counter width
// (R11) Sample record completes before branch store
// (R12) Interrupt held until sample, store finish
// (R13) Sampling on counter zero, enable bit 0
// (R14) Sampling only for listed event codes
// (R15) Sample records use 64-bit address entries
// (R16) Capability bit 6: trap-like versus fault-like
// (R17) Capability bit 7 always reads one
// (R18) Record format field reads 0000
// (R19) Capability present; bit 12 reports freeze
// (R20) Management interrupt freezes counting and tracing
// (R21) Resume sets enables, restores debug control
// (R22) Handler restores monitoring state before leaving
// (R23) Freeze enable set only when supported
// (R24) Wrap sets sticky overflow bit until cleared

`include "pfc_defines.svh"

module pfc_ctrl
   import pfc_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Register access
   input wire pfc_msr_s i_msr,
   output logic [`PFC_DW-1:0] o_msr_rdata,
   output logic o_msr_rvalid,
   // Core events
   input wire pfc_evt_s i_evt,
   input wire logic i_smi,
   input wire logic i_rsm,
   // Sample and branch-store engine
   input wire logic i_sample_done,
   input wire logic i_bstore_done,
   output logic o_sample_go,
   output logic o_sample_after,
   output logic [63:0] o_rec_ip,
   output logic o_bstore_go,
   // Status toward core
   output logic o_ovf_irq,
   output logic [15:0] o_dbg_ctl,
   output logic [12:0] o_fixed_info,
   output logic o_cap_present
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   pfc_regs_s r; // Registered state
   pfc_regs_s n; // Next state
   logic [`PFC_DW-1:0] cap; // Capability word
   logic wr_fx0; // Write to fixed counter 0
   logic wr_gc0; // Write to general counter 0
   logic wr_clr; // Write to overflow clear

   // Capability word, read only
   assign cap = {51'h0, `PFC_CAP_FRZ, `PFC_CAP_FMT, `PFC_CAP_ARCH, `PFC_CAP_TRAP, 6'h00}; // [R16] [R17] [R18] [R19]

   // Write strobes used by checks
   assign wr_fx0 = i_msr.wr && (i_msr.addr == `PFC_A_FX0);
   assign wr_gc0 = i_msr.wr && (i_msr.addr == `PFC_A_GC0);
   assign wr_clr = i_msr.wr && (i_msr.addr == `PFC_A_GCLR);

   // ---------------------------------------------
   // Next-state logic
   // ---------------------------------------------
   always_comb begin
      logic [`PFC_NFIX:0] inc;
      logic [`PFC_NFIX:0] wrap;
      logic [`PFC_NFIX:0] ien;
      logic [`PFC_NFIX:0] clr;
      logic elig;
      logic fire;
      inc = '0;
      wrap = '0;
      ien = '0;
      clr = '0;
      elig = 1'b0;
      fire = 1'b0;
      n = r;
      n.rvalid = 1'b0;
      n.irq = 1'b0;

      // Fixed counters: privilege filter, global enable
      for (int k = 0; k < `PFC_NFIX; k++) begin
         inc[k+1] = i_evt.fixed[k] & r.ge[k+1] & // [R6]
            ((r.fctl[`PFC_FC_W*k+`PFC_FC_OS] & i_evt.ring0) | // [R1] [R2] [R4]
             (r.fctl[`PFC_FC_W*k+`PFC_FC_USR] & ~i_evt.ring0)); // [R3] [R4]
         wrap[k+1] = inc[k+1] & (&r.fx_cnt[k]);
         ien[k+1] = r.fctl[`PFC_FC_W*k+`PFC_FC_INT]; // [R5]
         n.fx_cnt[k] = r.fx_cnt[k] + {{(`PFC_CW-1){1'b0}}, inc[k+1]};
      end

      // General counter zero
      inc[0] = i_evt.gen & r.ge[0] & r.evsel[`PFC_ES_EN] & // [R6]
         ((r.evsel[`PFC_ES_OS] & i_evt.ring0) | (r.evsel[`PFC_ES_USR] & ~i_evt.ring0));
      wrap[0] = inc[0] & (&r.gc0);
      ien[0] = r.evsel[`PFC_ES_INT];
      n.gc0 = r.gc0 + {{(`PFC_CW-1){1'b0}}, inc[0]};

      // Sampling-eligible select and mask pairs
      unique case ({r.evsel[7:0], r.evsel[15:8]})
         `PFC_EV_C0, `PFC_EV_C1, `PFC_EV_C5, `PFC_EV_C7: begin
            elig = 1'b1; // [R14]
         end
         `PFC_EV_CB1, `PFC_EV_CB2, `PFC_EV_CB4, `PFC_EV_CB8, `PFC_EV_CB10: begin
            elig = 1'b1; // [R14]
         end
         default: begin
            elig = 1'b0;
         end
      endcase

      // Sequencer: from idle, a pending sample goes ahead of a pending branch store
      unique case (r.st)
         PFC_IDLE: begin
            if (r.samp_pend) begin
               n.st = PFC_SAMPLE; // [R11]
            end else if (r.bts_pend) begin
               n.st = PFC_BSTORE;
            end
         end
         PFC_SAMPLE: begin
            if (i_sample_done) begin
               n.samp_pend = 1'b0;
               n.st = r.bts_pend ? PFC_BSTORE : PFC_IDLE; // [R11]
            end
         end
         PFC_BSTORE: begin
            if (i_bstore_done) begin
               n.bts_pend = 1'b0;
               n.st = PFC_IDLE;
            end
         end
         default: begin
            n.st = PFC_IDLE;
         end
      endcase

      // Arm a sample on counter-zero overflow; after the sequencer so a new request beats a done
      if (wrap[0] & r.sampen & elig) begin
         n.samp_pend = 1'b1; // [R13]
         n.rec_ip = i_evt.ip; // [R15]
      end

      // Branch store requests only when tracing is on; a new request beats a done
      if (i_evt.bts_req & r.dbg[`PFC_DBG_BTS]) begin
         n.bts_pend = 1'b1;
      end

      // Overflow interrupt waits for an idle sequencer
      fire = r.irq_pend & (r.st == PFC_IDLE) & ~r.samp_pend & ~r.bts_pend; // [R12]
      n.irq_pend = (r.irq_pend & ~fire) | (|(wrap & ien)); // [R5]
      n.irq = fire;

      // Register writes; a write beats a same-cycle count
      if (i_msr.wr) begin
         unique case (i_msr.addr)
            `PFC_A_FX0, `PFC_A_FX1, `PFC_A_FX2: begin
               n.fx_cnt[i_msr.addr[1:0]] = i_msr.wdata[`PFC_CW-1:0]; // [R10]
            end
            `PFC_A_GC0: begin
               n.gc0 = i_msr.wdata[`PFC_CW-1:0];
            end
            `PFC_A_EVSEL0: begin
               n.evsel = i_msr.wdata[31:0];
            end
            `PFC_A_FXCTL: begin
               n.fctl = i_msr.wdata[`PFC_NFIX*`PFC_FC_W-1:0]; // [R1]
            end
            `PFC_A_GEN: begin
               n.ge = {i_msr.wdata[`PFC_GS_FIX+`PFC_NFIX-1:`PFC_GS_FIX], i_msr.wdata[0]};
            end
            `PFC_A_GCLR: begin
               clr = {i_msr.wdata[`PFC_GS_FIX+`PFC_NFIX-1:`PFC_GS_FIX], i_msr.wdata[0]}; // [R8]
            end
            `PFC_A_SAMPEN: begin
               n.sampen = i_msr.wdata[0]; // [R13]
            end
            `PFC_A_DBG: begin
               n.dbg = i_msr.wdata[15:0] & `PFC_DBG_MASK;
            end
            default: begin
               n.sampen = r.sampen;
            end
         endcase
      end

      // Sticky overflow; a new wrap wins over a clear
      n.ovf = (r.ovf & ~clr) | wrap; // [R24] [R8]

      // Management interrupt entry and resume
      if (i_smi & r.dbg[`PFC_DBG_FRZ] & ~r.in_smm) begin
         n.sv_ge = n.ge;
         n.sv_dbg = n.dbg;
         n.ge = '0; // [R20]
         n.dbg = n.dbg & ~`PFC_DBG_OFF; // [R20]
         n.in_smm = 1'b1;
      end else if (i_rsm & r.in_smm) begin
         n.ge = '1; // [R21]
         n.dbg = r.sv_dbg; // [R21]
         n.in_smm = 1'b0;
      end

      // Register reads, answered one cycle later
      if (i_msr.rd) begin
         n.rvalid = 1'b1;
         unique case (i_msr.addr)
            `PFC_A_FX0, `PFC_A_FX1, `PFC_A_FX2: begin
               n.rdata = {24'h00_0000, r.fx_cnt[i_msr.addr[1:0]]};
            end
            `PFC_A_GC0: begin
               n.rdata = {24'h00_0000, r.gc0};
            end
            `PFC_A_EVSEL0: begin
               n.rdata = {32'h0000_0000, r.evsel};
            end
            `PFC_A_FXCTL: begin
               n.rdata = {52'h0_0000_0000_0000, r.fctl};
            end
            `PFC_A_GEN: begin
               n.rdata = {29'h0000_0000, r.ge[`PFC_NFIX:1], 31'h0000_0000, r.ge[0]};
            end
            `PFC_A_GSTAT: begin
               n.rdata = {29'h0000_0000, r.ovf[`PFC_NFIX:1], 31'h0000_0000, r.ovf[0]}; // [R7]
            end
            `PFC_A_SAMPEN: begin
               n.rdata = {63'h0, r.sampen};
            end
            `PFC_A_CAP: begin
               n.rdata = cap; // [R19]
            end
            `PFC_A_DBG: begin
               n.rdata = {48'h0000_0000_0000, r.dbg};
            end
            default: begin
               n.rdata = '0;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign o_msr_rdata = r.rdata;
   assign o_msr_rvalid = r.rvalid;
   assign o_sample_go = (r.st == PFC_SAMPLE);
   assign o_sample_after = `PFC_CAP_TRAP; // [R16]
   assign o_rec_ip = r.rec_ip;
   assign o_bstore_go = (r.st == PFC_BSTORE);
   assign o_ovf_irq = r.irq;
   assign o_dbg_ctl = r.dbg;
   assign o_fixed_info = {`PFC_INFO_W, `PFC_INFO_N}; // [R9]
   assign o_cap_present = 1'b1; // [R19]

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_smi_in;
      i_smi && r.dbg[`PFC_DBG_FRZ] && !r.in_smm;
   endsequence

   sequence s_rsm_in;
      i_rsm && r.in_smm;
   endsequence

   chk_ring0_count: assert property ( // [R2]
      (i_evt.fixed[0] && r.ge[1] && r.fctl[0] && i_evt.ring0 && !wr_fx0 && !i_smi)
      |=> r.fx_cnt[0] == $past(r.fx_cnt[0]) + 40'h1)
      else $error("fixed counter 0 missed a ring zero event");

   chk_halt_pair: assert property ( // [R4]
      (r.fctl[1:0] == 2'b00 && !wr_fx0) |=> $stable(r.fx_cnt[0]))
      else $error("halted fixed counter changed");

   chk_global_and: assert property ( // [R6]
      (!r.ge[0] && !wr_gc0) |=> $stable(r.gc0))
      else $error("counter moved with global enable off");

   chk_ovf_sticky: assert property ( // [R24]
      (r.ovf[1] && !wr_clr) |=> r.ovf[1])
      else $error("overflow bit dropped without clear");

   chk_ovf_clear: assert property ( // [R8]
      (wr_clr && i_msr.wdata[0] && !i_evt.gen) |=> !r.ovf[0])
      else $error("overflow bit not cleared");

   chk_irq_hold: assert property ( // [R12]
      o_ovf_irq |-> ($past(r.st) == PFC_IDLE) && !$past(r.samp_pend) && !$past(r.bts_pend))
      else $error("interrupt raised during store processing");

   // A pending interrupt survives while records are being written
   chk_irq_kept: assert property ( // [R12]
      (r.irq_pend && r.st != PFC_IDLE) |=> r.irq_pend)
      else $error("pending interrupt lost during store processing");

   // No sample is armed while sampling is switched off
   chk_sample_gate: assert property ( // [R13]
      (!r.sampen && !r.samp_pend) |=> !r.samp_pend)
      else $error("sample armed with sampling off");

   chk_sample_first: assert property ( // [R11]
      (r.st == PFC_IDLE && r.samp_pend && r.bts_pend) |=> o_sample_go ##0 !o_bstore_go)
      else $error("branch store ran before sample");

   chk_smi_freeze: assert property ( // [R20]
      s_smi_in |=> (r.ge == '0) && !r.dbg[`PFC_DBG_BTS] && !r.dbg[`PFC_DBG_LBR] && r.in_smm)
      else $error("freeze did not stop monitoring");

   chk_rsm_restore: assert property ( // [R21]
      s_rsm_in |=> (r.ge == '1) && (r.dbg == $past(r.sv_dbg)) && !r.in_smm)
      else $error("resume did not restore state");

   chk_cap_bits: assert property ( // [R17]
      (i_msr.rd && i_msr.addr == `PFC_A_CAP) |=> o_msr_rvalid && o_msr_rdata[7] && o_msr_rdata[12])
      else $error("capability read wrong");

endmodule

// ---- dv/pfc_engine_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------
// Record-writing engine beside the core
// ---------------------------------------------
module pfc_engine_model
   import pfc_pkg::*;
#(
   parameter int DLY = 3
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Requests from the control block
   input wire logic i_sample_go,
   input wire logic i_bstore_go,
   // Completion pulses
   output logic o_sample_done,
   output logic o_bstore_done
);
   int cnt; // Cycles spent on the current record

   // Answer each running job after DLY+1 cycles with one done pulse
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt <= 0;
         o_sample_done <= 1'b0;
         o_bstore_done <= 1'b0;
      end else begin
         o_sample_done <= 1'b0;
         o_bstore_done <= 1'b0;
         if ((i_sample_go || i_bstore_go) && !(o_sample_done || o_bstore_done)) begin
            // Only the job that is actually running is acknowledged
            if (cnt == DLY) begin
               cnt <= 0;
               o_sample_done <= i_sample_go;
               o_bstore_done <= i_bstore_go;
            end else begin
               cnt <= cnt + 1;
            end
         end else begin
            cnt <= 0;
         end
      end
   end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`include "pfc_defines.svh"
module testbench
   import pfc_pkg::*;
;
   logic i_clk, i_reset, i_smi, i_rsm;
   pfc_msr_s msr; // Register request
   pfc_evt_s evt; // Core events
   logic [63:0] rdata, rec_ip;
   logic rvalid, sdone, bdone, sgo, bgo, safter, irq, cap_p, sgo_q;
   logic [15:0] dbg;
   logic [12:0] finfo;
   int mismatches, num_checks, irq_cnt, irq_busy, go_cnt;
   localparam logic [63:0] ones40 = 64'h00FF_FFFF_FFFF;
   logic [15:0] pairs [9] = '{`PFC_EV_C0, `PFC_EV_C1, `PFC_EV_C5, `PFC_EV_C7,
      `PFC_EV_CB1, `PFC_EV_CB2, `PFC_EV_CB4, `PFC_EV_CB8, `PFC_EV_CB10};

   pfc_ctrl dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_msr(msr), .o_msr_rdata(rdata),
      .o_msr_rvalid(rvalid), .i_evt(evt), .i_smi(i_smi), .i_rsm(i_rsm), .i_sample_done(sdone),
      .i_bstore_done(bdone), .o_sample_go(sgo), .o_sample_after(safter), .o_rec_ip(rec_ip),
      .o_bstore_go(bgo), .o_ovf_irq(irq), .o_dbg_ctl(dbg), .o_fixed_info(finfo), .o_cap_present(cap_p));
   pfc_engine_model #(.DLY(3)) eng_u (.i_clk(i_clk), .i_reset(i_reset), .i_sample_go(sgo),
      .i_bstore_go(bgo), .o_sample_done(sdone), .o_bstore_done(bdone));

   // Clock of 4 ns
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // Count interrupts, interrupts during record work, sample starts
   always @(posedge i_clk) begin
      if (irq === 1'b1) irq_cnt++;
      if (irq === 1'b1 && (sgo || bgo)) irq_busy++;
      if (sgo === 1'b1 && sgo_q !== 1'b1) go_cnt++;
      sgo_q <= sgo;
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [3:0] a, input logic [63:0] d);
      @(posedge i_clk);
      msr.wr <= 1'b1;
      msr.addr <= a;
      msr.wdata <= d;
      @(posedge i_clk);
      msr.wr <= 1'b0;
   endtask

   // Read one register, answer one cycle after the request edge
   task rchk(input logic [3:0] a, input logic [63:0] exp);
      @(posedge i_clk);
      msr.rd <= 1'b1;
      msr.addr <= a;
      @(posedge i_clk);
      msr.rd <= 1'b0;
      #1;
      chk(64'(rvalid), 64'h1);
      chk(rdata, exp);
   endtask

   // One event pulse
   task ev(input logic [2:0] f, input logic g, input logic r0, input logic b);
      @(posedge i_clk);
      evt.fixed <= f;
      evt.gen <= g;
      evt.ring0 <= r0;
      evt.bts_req <= b;
      @(posedge i_clk);
      evt.fixed <= 3'h0;
      evt.gen <= 1'b0;
      evt.bts_req <= 1'b0;
   endtask

   task summarize;
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (6000) @(posedge i_clk);
      mismatches++;
      summarize;
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      i_reset = 1'b1;
      i_smi = 1'b0;
      i_rsm = 1'b0;
      msr = '0;
      evt = '0;
      evt.ip = 64'h1234_5678_9ABC_DEF0;
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      // Capability is read only and constant
      wr(`PFC_A_CAP, '1);
      rchk(`PFC_A_CAP, 64'h10C0);
      chk(64'(finfo), 64'h0503);
      chk(64'(cap_p), 64'h1);
      chk(64'(safter), 64'h1);
      rchk(4'hF, 64'h0);
      // Every enable pair at both privilege levels
      wr(`PFC_A_GEN, 64'h7_0000_0001);
      for (int e = 0; e < 4; e++) begin
         for (int r = 0; r < 2; r++) begin
            wr(`PFC_A_FXCTL, 64'(e));
            wr(`PFC_A_FX0, 64'h0);
            ev(3'h7, 1'b0, r[0], 1'b0);
            rchk(`PFC_A_FX0, 64'((r == 1) ? e % 2 : e / 2));
         end
      end
      rchk(`PFC_A_FX1, 64'h0);
      // Global bit off stops a locally enabled counter
      wr(`PFC_A_GEN, 64'h0);
      wr(`PFC_A_FX0, 64'h0);
      ev(3'h1, 1'b0, 1'b1, 1'b0);
      rchk(`PFC_A_FX0, 64'h0);
      // Wrap of fixed counter 1 with its interrupt bit
      wr(`PFC_A_GEN, 64'h7_0000_0001);
      wr(`PFC_A_FXCTL, 64'h0090);
      wr(`PFC_A_FX1, ones40);
      ev(3'h2, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge i_clk);
      rchk(`PFC_A_GSTAT, 64'h2_0000_0000);
      rchk(`PFC_A_FX1, 64'h0);
      chk(64'(irq_cnt), 64'h1);
      wr(`PFC_A_GCLR, 64'h2_0000_0000);
      rchk(`PFC_A_GSTAT, 64'h0);
      // Sample and branch store from one instruction
      wr(`PFC_A_EVSEL0, 64'h0052_00C0);
      wr(`PFC_A_GC0, ones40);
      wr(`PFC_A_SAMPEN, 64'h1);
      wr(`PFC_A_DBG, 64'h0080);
      wr(`PFC_A_GEN, 64'h1);
      ev(3'h0, 1'b1, 1'b1, 1'b1);
      #1;
      for (int k = 0; k < 20 && sgo !== 1'b1; k++) begin
         @(posedge i_clk);
         #1;
      end
      chk(64'(bgo), 64'h0);
      chk(rec_ip, 64'h1234_5678_9ABC_DEF0);
      for (int k = 0; k < 20 && bgo !== 1'b1; k++) begin
         @(posedge i_clk);
         #1;
      end
      chk(64'(sgo), 64'h0);
      repeat (10) @(posedge i_clk);
      chk(64'(irq_cnt), 64'h2);
      chk(64'(irq_busy), 64'h0);
      rchk(`PFC_A_GSTAT, 64'h1);
      wr(`PFC_A_GCLR, 64'h1);
      rchk(`PFC_A_GSTAT, 64'h0);
      // Every eligible select and mask pair starts a sample
      for (int i = 0; i < 9; i++) begin
         wr(`PFC_A_EVSEL0, {48'h52, pairs[i][7:0], pairs[i][15:8]});
         wr(`PFC_A_GC0, ones40);
         ev(3'h0, 1'b1, 1'b1, 1'b0);
         repeat (12) @(posedge i_clk);
         chk(64'(go_cnt), 64'(i + 2));
      end
      // Ineligible mask, then sampling switched off
      wr(`PFC_A_EVSEL0, 64'h0052_01C0);
      wr(`PFC_A_GC0, ones40);
      ev(3'h0, 1'b1, 1'b1, 1'b0);
      repeat (12) @(posedge i_clk);
      chk(64'(go_cnt), 64'hA);
      wr(`PFC_A_SAMPEN, 64'h0);
      wr(`PFC_A_EVSEL0, 64'h0052_00C0);
      wr(`PFC_A_GC0, ones40);
      ev(3'h0, 1'b1, 1'b1, 1'b0);
      repeat (12) @(posedge i_clk);
      chk(64'(go_cnt), 64'hA);
      // Freeze only because the capability reports it
      wr(`PFC_A_DBG, 64'h4081);
      wr(`PFC_A_GEN, 64'h7_0000_0001);
      @(posedge i_clk);
      i_smi <= 1'b1;
      @(posedge i_clk);
      i_smi <= 1'b0;
      #1;
      chk(64'(dbg), 64'h4000);
      rchk(`PFC_A_GEN, 64'h0);
      // Handler leaves monitoring state untouched before resuming
      @(posedge i_clk);
      i_rsm <= 1'b1;
      @(posedge i_clk);
      i_rsm <= 1'b0;
      #1;
      chk(64'(dbg), 64'h4081);
      rchk(`PFC_A_GEN, 64'h7_0000_0001);
      summarize;
   end
endmodule
